// File: rtl/ctac_pkg.sv
// constants shared by the transmit abort control block
package ctac_pkg;
   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] BUF0_CTRL_OFS = 8'h30;
   localparam logic [7:0] BUF1_CTRL_OFS = 8'h40;
   localparam logic [7:0] BUF2_CTRL_OFS = 8'h50;
   localparam logic [7:0] CTRL_OFS = 8'h0F;
   // ****************************************
   // field positions
   // ****************************************
   localparam int CANCELLED_BIT = 6;
   localparam int ARB_LOST_BIT = 5;
   localparam int SEND_ERR_BIT = 4;
   localparam int PENDING_BIT = 3;
   localparam int PRIO_LSB = 0;
   localparam int CANCEL_ALL_BIT = 4;
   // ****************************************
   // reset values and sizes
   // ****************************************
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [1:0] PRIO_RESET = 2'h0;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam int NUM_BUF = 3;
endpackage

// File: rtl/ctac_buffer_slice.sv
// control and status bits of one transmit buffer
`timescale 1ns/1ps
`default_nettype none
module ctac_buffer_slice
   import ctac_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // host write
   input wire logic wr_hit,
   input wire logic [7:0] wr_data,
   // global cancel
   input wire logic cancel_all,
   // engine events for this buffer
   input wire logic start,
   input wire logic done,
   input wire logic arb_lost,
   input wire logic bus_error,
   // state
   output logic [7:0] ctrl_value,
   output logic [1:0] send_priority,
   output logic started
);
   logic send_pending_ff;
   logic cancelled_flag_ff;
   logic arbitration_lost_flag_ff;
   logic send_error_flag_ff;
   logic started_ff;
   logic [1:0] send_priority_ff;
   logic set_req;

   assign set_req = wr_hit && wr_data[PENDING_BIT] && !send_pending_ff;

   // ****************************************
   // transmit request
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         send_pending_ff <= 1'b0;
      end else if (done && started_ff) begin
         send_pending_ff <= 1'b0;
      end else if (wr_hit && wr_data[PENDING_BIT]) begin
         send_pending_ff <= 1'b1;
      end else if (wr_hit && !started_ff) begin
         send_pending_ff <= 1'b0;
      end else if (cancel_all && !started_ff) begin
         send_pending_ff <= 1'b0;
      end
   end

   // ****************************************
   // frame under way, held across retries
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         started_ff <= 1'b0;
      end else if (done) begin
         started_ff <= 1'b0;
      end else if (start && send_pending_ff) begin
         started_ff <= 1'b1;
      end
   end

   // ****************************************
   // status flags
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cancelled_flag_ff <= 1'b0;
      end else if (cancel_all && send_pending_ff && !started_ff && !(wr_hit && wr_data[PENDING_BIT])) begin
         cancelled_flag_ff <= 1'b1;
      end else if (set_req) begin
         cancelled_flag_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         arbitration_lost_flag_ff <= 1'b0;
      end else if (arb_lost && started_ff) begin
         arbitration_lost_flag_ff <= 1'b1;
      end else if (set_req) begin
         arbitration_lost_flag_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         send_error_flag_ff <= 1'b0;
      end else if (bus_error && started_ff) begin
         send_error_flag_ff <= 1'b1;
      end else if (set_req) begin
         send_error_flag_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         send_priority_ff <= PRIO_RESET;
      end else if (wr_hit && !started_ff) begin
         send_priority_ff <= wr_data[PRIO_LSB +: 2];
      end
   end

   assign ctrl_value = {1'b0, cancelled_flag_ff, arbitration_lost_flag_ff, send_error_flag_ff,
                        send_pending_ff, 1'b0, send_priority_ff};
   assign send_priority = send_priority_ff;
   assign started = started_ff;
endmodule
`default_nettype wire

// File: rtl/ctac_tx_abort_control.sv
// transmit buffer control, priority choice and abort logic
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - host clears a buffer's send request to cancel it if not yet started
// - setting cancel-all cancels every buffer still waiting to send
// - cancelled flag is set only by a cancel-all cancellation
// - cancelling by clearing the send request leaves the cancelled flag alone
// - only frames not yet started on the bus can be cancelled
// - host clears of the send request are ignored once the frame started
// - a started frame that errs or loses arbitration is queued again
// - send error flag, bit 4, shows a bus error during this buffer's frame
// - send request, bit 3, reads one while the buffer waits to send
// - send request clears itself after a successful send
// - setting the send request clears cancelled, arbitration and error flags
// - priority 11 is highest, 00 lowest; ties go to the higher buffer
// - lost arbitration keeps the request set and sets the arbitration flag
module ctac_tx_abort_control
   import ctac_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register access from the serial command decoder
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // protocol engine
   output logic offer_valid,
   output logic [1:0] offer_index,
   input wire logic eng_start,
   input wire logic eng_done,
   input wire logic eng_arb_lost,
   input wire logic eng_bus_error,
   // controller control state
   output logic cancel_all_request
);
   localparam logic [NUM_BUF-1:0][7:0] BUF_OFS = {BUF2_CTRL_OFS, BUF1_CTRL_OFS, BUF0_CTRL_OFS};

   logic [7:0] controller_control_ff;
   logic [7:0] reg_rdata_ff;
   logic [1:0] offer_index_ff;
   logic offer_ok_ff;
   logic [NUM_BUF-1:0] wr_hit;
   logic [NUM_BUF-1:0] eng_sel;
   logic [NUM_BUF-1:0] pending;
   logic [NUM_BUF-1:0] started;
   logic [NUM_BUF-1:0][7:0] ctrl_value;
   logic [NUM_BUF-1:0][1:0] prio;
   logic cancel_all;
   logic nxt_offer_ok;
   logic [1:0] nxt_offer_index;
   logic [1:0] best_prio;
   logic [7:0] rd_mux;

   assign cancel_all = controller_control_ff[CANCEL_ALL_BIT];

   // ****************************************
   // buffer slices
   // ****************************************
   for (genvar i = 0; i < NUM_BUF; i++) begin : g_buf
      assign wr_hit[i] = reg_wr && (reg_addr == BUF_OFS[i]);
      assign eng_sel[i] = (offer_index_ff == 2'(i));
      assign pending[i] = ctrl_value[i][PENDING_BIT];
      ctac_buffer_slice u_slice (
         .clk(clk),
         .rst_n(rst_n),
         .wr_hit(wr_hit[i]),
         .wr_data(reg_wdata),
         .cancel_all(cancel_all),
         .start(eng_start && offer_valid && eng_sel[i]),
         .done(eng_done && started[i]),
         .arb_lost(eng_arb_lost && started[i]),
         .bus_error(eng_bus_error && started[i]),
         .ctrl_value(ctrl_value[i]),
         .send_priority(prio[i]),
         .started(started[i])
      );
   end

   // ****************************************
   // controller control register
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         controller_control_ff <= CTRL_RESET;
      end else if (reg_wr && reg_addr == CTRL_OFS) begin
         controller_control_ff <= reg_wdata;
      end
   end

   // ****************************************
   // register read
   // ****************************************
   always_comb begin
      rd_mux = UNMAPPED_READ;
      if (reg_addr == CTRL_OFS) begin
         rd_mux = controller_control_ff;
      end
      for (int i = 0; i < NUM_BUF; i++) begin
         if (reg_addr == BUF_OFS[i]) begin
            rd_mux = ctrl_value[i];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_ff <= UNMAPPED_READ;
      end else if (reg_rd) begin
         reg_rdata_ff <= rd_mux;
      end
   end

   // ****************************************
   // choice of next buffer to send
   // ****************************************
   always_comb begin
      nxt_offer_ok = 1'b0;
      nxt_offer_index = 2'h0;
      best_prio = 2'h0;
      for (int i = 0; i < NUM_BUF; i++) begin
         if (pending[i] && !cancel_all && (!nxt_offer_ok || prio[i] >= best_prio)) begin
            nxt_offer_ok = 1'b1;
            nxt_offer_index = 2'(i);
            best_prio = prio[i];
         end
      end
      for (int i = 0; i < NUM_BUF; i++) begin
         if (started[i]) begin
            nxt_offer_ok = 1'b1;
            nxt_offer_index = 2'(i);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         offer_ok_ff <= 1'b0;
         offer_index_ff <= 2'h0;
      end else begin
         offer_ok_ff <= nxt_offer_ok;
         offer_index_ff <= nxt_offer_index;
      end
   end

   assign offer_valid = offer_ok_ff && pending[offer_index_ff] && (started[offer_index_ff] || !cancel_all);
   assign offer_index = offer_index_ff;
   assign reg_rdata = reg_rdata_ff;
   assign cancel_all_request = cancel_all;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // ****************************************
   // send request checks
   // ****************************************
   host_cancel_a: assert property (wr_hit[0] && !reg_wdata[PENDING_BIT] && pending[0]
      && !started[0] && !cancel_all |=> !pending[0] && $stable(ctrl_value[0][CANCELLED_BIT]))
      else $error("host cancel wrong");
   started_hold_a: assert property (started[2] && pending[2] && wr_hit[2] && !eng_done
      |=> pending[2]) else $error("started frame was cancelled");
   cancel_all_a: assert property (cancel_all && pending[1] && !started[1] && !wr_hit[1]
      |=> !pending[1] && ctrl_value[1][CANCELLED_BIT]) else $error("cancel-all missed buffer");
   retry_keep_a: assert property ((eng_bus_error || eng_arb_lost) && started[2]
      |=> pending[2] && started[2]) else $error("failed frame not requeued");
   done_clear_a: assert property (eng_done && started[2] |=> !pending[2] && !started[2])
      else $error("done did not clear request");
   cancel_keep_a: assert property (cancel_all && started[2] && !eng_done |=> pending[2])
      else $error("started frame cancelled by cancel-all");
   host_set_a: assert property (wr_hit[1] && reg_wdata[PENDING_BIT] && !eng_done |=> pending[1])
      else $error("send request not set");

   // ****************************************
   // status flag checks
   // ****************************************
   cancel_source_a: assert property ($rose(ctrl_value[0][CANCELLED_BIT]) |-> $past(cancel_all))
      else $error("cancelled flag set without cancel-all");
   error_flag_a: assert property (eng_bus_error && started[2] && !eng_arb_lost
      |=> ctrl_value[2][SEND_ERR_BIT] && $stable(ctrl_value[2][ARB_LOST_BIT]))
      else $error("error flag not set");
   err_keep_a: assert property (!ctrl_value[2][SEND_ERR_BIT] && !(eng_bus_error && started[2])
      |=> !ctrl_value[2][SEND_ERR_BIT]) else $error("error flag set without bus error");
   set_clear_a: assert property ($rose(pending[0]) |-> ctrl_value[0][6:4] == 3'h0)
      else $error("flags not cleared on new request");
   arb_flag_a: assert property (eng_arb_lost && started[2] |=> ctrl_value[2][ARB_LOST_BIT] && pending[2])
      else $error("arbitration flag wrong");
   arb_keep_a: assert property (!ctrl_value[2][ARB_LOST_BIT] && !(eng_arb_lost && started[2])
      |=> !ctrl_value[2][ARB_LOST_BIT]) else $error("arbitration flag set without loss");
   host_flag_a: assert property (wr_hit[1] && !reg_wdata[PENDING_BIT] && !cancel_all
      |=> $stable(ctrl_value[1][CANCELLED_BIT])) else $error("host cancel touched cancelled flag");
   reserved_a: assert property (reg_rd && reg_addr == BUF0_CTRL_OFS
      |=> reg_rdata[7] == 1'b0 && reg_rdata[2] == 1'b0) else $error("reserved bits not zero");

   // ****************************************
   // offer checks
   // ****************************************
   offer_pend_a: assert property (offer_valid |-> pending[offer_index] ##1 (pending[$past(offer_index)]
      || $past(eng_done) || cancel_all || $past(wr_hit != 3'h0)))
      else $error("offer of idle buffer");
   prio_tie_a: assert property (!cancel_all && started == 3'h0 && pending[1:0] == 2'h3 && prio[1] >= prio[0]
      |=> offer_index != 2'h0) else $error("lower buffer won a tie");
   prio_high_a: assert property (!cancel_all && started == 3'h0 && pending[2] && prio[2] >= prio[1]
      && prio[2] >= prio[0] |=> offer_index == 2'h2) else $error("highest buffer not offered");
   offer_block_a: assert property (cancel_all && started == 3'h0 |-> !offer_valid)
      else $error("offer during cancel-all");

   // ****************************************
   // cover points
   // ****************************************
   send_ok_c: cover property (eng_start && offer_valid ##[1:50] eng_done);
   cancel_all_c: cover property (cancel_all && pending != 3'h0 ##1 pending == 3'h0);
   retry_c: cover property (eng_arb_lost && started != 3'h0 ##[1:50] eng_done);
   protect_c: cover property (cancel_all && started != 3'h0 ##1 eng_bus_error);
   host_cancel_c: cover property (wr_hit != 3'h0 && !reg_wdata[PENDING_BIT] && pending != 3'h0);
endmodule
`default_nettype wire

// File: tb/ctac_host_model.sv
// host model driving the register bus of the abort control block
`timescale 1ns/1ps
`default_nettype none
module ctac_host_model
   import ctac_pkg::*;
(
   // clock
   input wire logic clk,
   // register bus
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   // ****************************************
   // byte access
   // ****************************************
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
   end
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(posedge clk);
      reg_addr <= addr;
      reg_wdata <= data;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_addr <= ~addr;
      reg_wdata <= ~data;
   endtask
   task automatic rd(input logic [7:0] addr, output logic [7:0] data);
      @(posedge clk);
      reg_addr <= addr;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_addr <= ~addr;
      @(posedge clk);
      data = reg_rdata;
   endtask
   // looks at every buffer, then drops cancel-all
   task automatic end_cancel_all();
      logic [7:0] d;
      for (int i = 0; i < NUM_BUF; i++) begin
         rd(BUF0_CTRL_OFS + 8'(16 * i), d);
      end
      wr(CTRL_OFS, CTRL_RESET);
   endtask
endmodule
`default_nettype wire

// File: tb/ctac_tx_abort_control_tb.sv
// self-checking bench for the transmit abort control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
   $display("BAD %s expected %h seen %h", what, exp, got); end end
module ctac_tx_abort_control_tb
   import ctac_pkg::*;
;
   logic clk, rst_n, reg_wr, reg_rd, offer_valid, cancel_all_request;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [1:0] offer_index;
   logic eng_start, eng_done, eng_arb_lost, eng_bus_error;
   int num_errors = 0;
   int tests_run = 0;
   int cycles = 0;
   ctac_tx_abort_control dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .offer_valid(offer_valid),
      .offer_index(offer_index), .eng_start(eng_start), .eng_done(eng_done), .eng_arb_lost(eng_arb_lost),
      .eng_bus_error(eng_bus_error), .cancel_all_request(cancel_all_request));
   ctac_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   // ****************************************
   // helpers
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk_reg(input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] d;
      host.rd(addr, d);
      `CHK("register read", exp, d)
   endtask
   task automatic eng(input logic [3:0] ev);
      @(posedge clk);
      {eng_start, eng_done, eng_arb_lost, eng_bus_error} <= ev;
      @(posedge clk);
      {eng_start, eng_done, eng_arb_lost, eng_bus_error} <= 4'h0;
   endtask
   task automatic settle();
      repeat (3) @(posedge clk);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      chk_reg(BUF0_CTRL_OFS, 8'h00);
      chk_reg(BUF2_CTRL_OFS, 8'h00);
      host.wr(8'h20, 8'hFF);
      chk_reg(8'h20, UNMAPPED_READ);
      chk_reg(CTRL_OFS, CTRL_RESET);
      host.wr(BUF1_CTRL_OFS, 8'hF4);
      chk_reg(BUF1_CTRL_OFS, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_single();
      host.wr(BUF0_CTRL_OFS, 8'h0B);
      chk_reg(BUF0_CTRL_OFS, 8'h0B);
      `CHK("offer valid", 1'b1, offer_valid)
      host.wr(BUF0_CTRL_OFS, 8'h03);
      chk_reg(BUF0_CTRL_OFS, 8'h03);
      settle();
      `CHK("offer valid", 1'b0, offer_valid)
      $display("test single cancel done");
   endtask
   task automatic t_prio();
      host.wr(BUF0_CTRL_OFS, 8'h0A);
      host.wr(BUF1_CTRL_OFS, 8'h0A);
      host.wr(BUF2_CTRL_OFS, 8'h09);
      settle();
      `CHK("offer index", 2'h1, offer_index)
      host.wr(BUF2_CTRL_OFS, 8'h0B);
      settle();
      `CHK("offer index", 2'h2, offer_index)
      $display("test priority done");
   endtask
   task automatic t_started();
      eng(4'h8);
      host.wr(BUF2_CTRL_OFS, 8'h00);
      chk_reg(BUF2_CTRL_OFS, 8'h0B);
      eng(4'h1);
      chk_reg(BUF2_CTRL_OFS, 8'h1B);
      eng(4'h2);
      chk_reg(BUF2_CTRL_OFS, 8'h3B);
      eng(4'h4);
      chk_reg(BUF2_CTRL_OFS, 8'h33);
      host.wr(BUF2_CTRL_OFS, 8'h0B);
      chk_reg(BUF2_CTRL_OFS, 8'h0B);
      $display("test started frame done");
   endtask
   task automatic t_cancel_all();
      settle();
      eng(4'h8);
      host.wr(CTRL_OFS, 8'h10);
      @(posedge clk);
      `CHK("cancel all", 1'b1, cancel_all_request)
      chk_reg(BUF0_CTRL_OFS, 8'h42);
      chk_reg(BUF1_CTRL_OFS, 8'h42);
      eng(4'h1);
      chk_reg(BUF2_CTRL_OFS, 8'h1B);
      `CHK("offer valid", 1'b1, offer_valid)
      eng(4'h4);
      host.end_cancel_all();
      @(posedge clk);
      `CHK("cancel all", 1'b0, cancel_all_request)
      host.wr(BUF0_CTRL_OFS, 8'h0B);
      chk_reg(BUF0_CTRL_OFS, 8'h0B);
      $display("test cancel all done");
   endtask
   initial begin
      rst_n = 1'b0;
      {eng_start, eng_done, eng_arb_lost, eng_bus_error} = 4'h0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_single();
      t_prio();
      t_started();
      t_cancel_all();
      finish_test();
   end
endmodule
`default_nettype wire
